/* inc/uart_ctrl_pkg.sv */
// constants, types and helpers shared by the serial port control register and its receive fifo
package uart_ctrl_pkg;

    // register addresses on the special function bus
    localparam logic [7:0] CONTROL_ADDR = 8'h00_c8;
    localparam logic [7:0] DATA_ADDR = 8'h00_99;
    localparam logic [7:0] CONTROL_RESET = 8'h00_00;
    localparam logic [7:0] READ_IDLE = 8'h00_00;

    // bit positions inside the control register
    localparam int OVERRUN_POS = 7;
    localparam int PARITY_ERR_POS = 6;
    localparam int RESERVED_POS = 5;
    localparam int RX_ENABLE_POS = 4;
    localparam int TX_EXTRA_POS = 3;
    localparam int RX_EXTRA_POS = 2;
    localparam int TX_DONE_POS = 1;
    localparam int RX_PENDING_POS = 0;

    // receive fifo geometry
    localparam int FIFO_DEPTH = 2;
    localparam int FIFO_PTR_W = 1;
    localparam int FIFO_CNT_W = 2;

    // parity type selector codes
    localparam logic [1:0] PARITY_ODD = 2'h0;
    localparam logic [1:0] PARITY_EVEN = 2'h1;
    localparam logic [1:0] PARITY_MARK = 2'h2;
    localparam logic [1:0] PARITY_SPACE = 2'h3;

    // one character as delivered by the receive shifter
    typedef struct packed {
        logic valid;
        logic [7:0] data;
        logic extra;
        logic stop;
    } rx_char_type;

    // one fifo entry
    typedef struct packed {
        logic [7:0] data;
        logic extra;
        logic stop;
        logic parity_bad;
    } rx_entry_type;

    // true when the received parity bit disagrees with the selected type
    function automatic logic parity_mismatch(input logic [7:0] data, input logic pbit,
                                             input logic [1:0] ptype);
        logic expect_bit;
        expect_bit = 1'b0;
        case (ptype)
            PARITY_ODD: expect_bit = ~(^data);
            PARITY_EVEN: expect_bit = ^data;
            PARITY_MARK: expect_bit = 1'b1;
            default: expect_bit = 1'b0;
        endcase
        return pbit != expect_bit;
    endfunction : parity_mismatch

    // new value of one control bit after a byte or bit write
    function automatic logic apply_write(input logic cur, input logic [7:0] mask,
                                         input logic [7:0] val, input int pos);
        return mask[pos] ? val[pos] : cur;
    endfunction : apply_write

endpackage : uart_ctrl_pkg

/* hw/rx_byte_fifo.sv */
// receive fifo holding characters until software reads the data buffer
`timescale 1ns/10ps
module rx_byte_fifo (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic push,
    input uart_ctrl_pkg::rx_entry_type push_entry,
    input wire logic pop,
    output uart_ctrl_pkg::rx_entry_type head,
    output logic full,
    output logic empty
);
    uart_ctrl_pkg::rx_entry_type mem [uart_ctrl_pkg::FIFO_DEPTH];
    logic [uart_ctrl_pkg::FIFO_PTR_W-1:0] wr_ptr;
    logic [uart_ctrl_pkg::FIFO_PTR_W-1:0] rd_ptr;
    logic [uart_ctrl_pkg::FIFO_CNT_W-1:0] count;
    logic [uart_ctrl_pkg::FIFO_PTR_W-1:0] next_wr_ptr;
    logic [uart_ctrl_pkg::FIFO_PTR_W-1:0] next_rd_ptr;
    logic [uart_ctrl_pkg::FIFO_CNT_W-1:0] next_count;
    logic do_push;
    logic do_pop;

    assign full = count == uart_ctrl_pkg::FIFO_CNT_W'(uart_ctrl_pkg::FIFO_DEPTH);
    assign empty = count == '0;
    assign head = mem[rd_ptr];

    // pointer and count update; callers never push when full nor pop when empty
    always_comb begin
        do_push = push && !full;
        do_pop = pop && !empty;
        next_wr_ptr = do_push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = do_pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count = count;
        if (do_push && !do_pop) begin
            next_count = count + 1'b1;
        end else if (do_pop && !do_push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

    // storage has no reset; only written slots are ever read out
    always_ff @(posedge ref_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= push_entry;
        end
    end

endmodule : rx_byte_fifo

/* hw/uart_serial_control.sv */
// serial port control and status register with its receive path
`timescale 1ns/10ps
module uart_serial_control (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_bit_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_bit_val,
    input uart_ctrl_pkg::rx_char_type rx_char,
    input wire logic rx_parity_bit,
    input wire logic tx_done,
    input wire logic parity_enable,
    input wire logic [1:0] parity_type,
    input wire logic extra_bit_mode_enable,
    input wire logic multiproc_enable,
    output logic [7:0] sfr_rdata,
    output logic rx_overrun_flag,
    output logic parity_error_flag,
    output logic receive_enable,
    output logic transmit_extra_bit,
    output logic extra_receive_bit,
    output logic transmit_done_flag,
    output logic receive_pending_flag
);
    // fifo connections
    uart_ctrl_pkg::rx_entry_type push_entry;
    uart_ctrl_pkg::rx_entry_type head;
    uart_ctrl_pkg::rx_entry_type last_entry;
    uart_ctrl_pkg::rx_entry_type shown;
    uart_ctrl_pkg::rx_entry_type next_last_entry;
    logic push;
    logic pop;
    logic full;
    logic empty;

    // decoded software access
    logic control_hit;
    logic control_bit_hit;
    logic data_read;
    logic [7:0] wr_mask;
    logic [7:0] wr_val;

    // next values of the control register bits and read data
    logic next_overrun;
    logic next_parity_err;
    logic next_rx_enable;
    logic next_tx_extra;
    logic next_tx_done;
    logic next_rx_extra;
    logic next_rx_pending;
    logic [7:0] next_rdata;
    logic [7:0] control_view;
    logic char_accept;
    logic overrun_event;
    logic parity_event;

    rx_byte_fifo u_rx_fifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .push(push),
        .push_entry(push_entry),
        .pop(pop),
        .head(head),
        .full(full),
        .empty(empty)
    );

    // address decode for byte access and single bit access of the control register
    always_comb begin
        control_hit = sfr_addr == uart_ctrl_pkg::CONTROL_ADDR;
        control_bit_hit = sfr_addr[7:3] == uart_ctrl_pkg::CONTROL_ADDR[7:3];
        data_read = sfr_rd && sfr_addr == uart_ctrl_pkg::DATA_ADDR;
        wr_mask = 8'h00_00;
        wr_val = 8'h00_00;
        if (sfr_wr && control_hit) begin
            wr_mask = 8'h00_ff;
            wr_val = sfr_wdata;
        end else if (sfr_bit_wr && control_bit_hit) begin
            wr_mask = 8'h00_01 << sfr_addr[2:0];
            wr_val = {8{sfr_bit_val}};
        end
    end

    // receive path: filter by multiprocessor mode, drop when disabled, flag when full
    always_comb begin
        char_accept = !multiproc_enable
            || (extra_bit_mode_enable ? rx_char.extra : rx_char.stop);
        push = rx_char.valid && receive_enable && char_accept && !full;
        overrun_event = rx_char.valid && receive_enable && char_accept && full;
        push_entry.data = rx_char.data;
        push_entry.extra = rx_char.extra;
        push_entry.stop = rx_char.stop;
        push_entry.parity_bad = uart_ctrl_pkg::parity_mismatch(rx_char.data, rx_parity_bit,
                                                               parity_type);
    end

    // reading the data buffer pops the head; an empty buffer replays the last byte
    always_comb begin
        pop = data_read && !empty;
        shown = empty ? last_entry : head;
        next_last_entry = pop ? head : last_entry;
        parity_event = parity_enable && !empty && head.parity_bad;
    end

    // control bits: hardware set wins over a software clear in the same cycle
    always_comb begin
        next_overrun = uart_ctrl_pkg::apply_write(rx_overrun_flag, wr_mask, wr_val,
                                                  uart_ctrl_pkg::OVERRUN_POS)
            | overrun_event;
        next_parity_err = uart_ctrl_pkg::apply_write(parity_error_flag, wr_mask, wr_val,
                                                     uart_ctrl_pkg::PARITY_ERR_POS)
            | parity_event;
        next_rx_enable = uart_ctrl_pkg::apply_write(receive_enable, wr_mask, wr_val,
                                                    uart_ctrl_pkg::RX_ENABLE_POS);
        next_tx_extra = uart_ctrl_pkg::apply_write(transmit_extra_bit, wr_mask, wr_val,
                                                   uart_ctrl_pkg::TX_EXTRA_POS);
        next_tx_done = uart_ctrl_pkg::apply_write(transmit_done_flag, wr_mask, wr_val,
                                                  uart_ctrl_pkg::TX_DONE_POS)
            | tx_done;
        // status bits follow the buffer only; write mask is not applied to them
        next_rx_extra = extra_bit_mode_enable ? shown.extra : shown.stop;
        next_rx_pending = !empty;
    end

    // read data assembled from live register state
    always_comb begin
        control_view = uart_ctrl_pkg::CONTROL_RESET;
        control_view[uart_ctrl_pkg::OVERRUN_POS] = rx_overrun_flag;
        control_view[uart_ctrl_pkg::PARITY_ERR_POS] = parity_error_flag;
        control_view[uart_ctrl_pkg::RESERVED_POS] = 1'b0;
        control_view[uart_ctrl_pkg::RX_ENABLE_POS] = receive_enable;
        control_view[uart_ctrl_pkg::TX_EXTRA_POS] = transmit_extra_bit;
        control_view[uart_ctrl_pkg::RX_EXTRA_POS] = extra_bit_mode_enable ? shown.extra
                                                                           : shown.stop;
        control_view[uart_ctrl_pkg::TX_DONE_POS] = transmit_done_flag;
        control_view[uart_ctrl_pkg::RX_PENDING_POS] = !empty;
        next_rdata = uart_ctrl_pkg::READ_IDLE;
        if (sfr_rd && control_hit) begin
            next_rdata = control_view;
        end else if (data_read) begin
            next_rdata = shown.data;
        end
    end

    // register stage for control bits, status copies and read data
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rx_overrun_flag <= 1'b0;
            parity_error_flag <= 1'b0;
            receive_enable <= 1'b0;
            transmit_extra_bit <= 1'b0;
            transmit_done_flag <= 1'b0;
            extra_receive_bit <= 1'b0;
            receive_pending_flag <= 1'b0;
            sfr_rdata <= uart_ctrl_pkg::READ_IDLE;
            last_entry <= '0;
        end else begin
            rx_overrun_flag <= next_overrun;
            parity_error_flag <= next_parity_err;
            receive_enable <= next_rx_enable;
            transmit_extra_bit <= next_tx_extra;
            transmit_done_flag <= next_tx_done;
            extra_receive_bit <= next_rx_extra;
            receive_pending_flag <= next_rx_pending;
            sfr_rdata <= next_rdata;
            last_entry <= next_last_entry;
        end
    end

endmodule : uart_serial_control

/* bench/uart_serial_control_asserts.sv */
// concurrent checks on the serial control register ports
`timescale 1ns/10ps
module uart_serial_control_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_bit_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic sfr_bit_val,
    input uart_ctrl_pkg::rx_char_type rx_char,
    input wire logic multiproc_enable,
    input wire logic [7:0] sfr_rdata,
    input wire logic rx_overrun_flag,
    input wire logic parity_error_flag,
    input wire logic receive_enable,
    input wire logic transmit_extra_bit,
    input wire logic receive_pending_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    // software clears of the sticky flags, byte or bit wide
    logic clr_ovr;
    logic clr_parity_error_flag;
    assign clr_ovr = (sfr_wr && sfr_addr == 8'h00_c8 && !sfr_wdata[7])
        || (sfr_bit_wr && sfr_addr == 8'h00_cf && !sfr_bit_val);
    assign clr_parity_error_flag = (sfr_wr && sfr_addr == 8'h00_c8 && !sfr_wdata[6])
        || (sfr_bit_wr && sfr_addr == 8'h00_ce && !sfr_bit_val);
    ovr_sticky_a: assert property (rx_overrun_flag && !clr_ovr |=> rx_overrun_flag)
        else $error("overrun flag dropped without a clear");
    parity_error_flag_sticky_a: assert property (parity_error_flag && !clr_parity_error_flag |=> parity_error_flag)
        else $error("parity flag dropped without a clear");
    reset_clear_a: assert property ($fell(rst) |-> !rx_overrun_flag && !parity_error_flag)
        else $error("flags not clear after reset");
    rsvd_read_a: assert property (sfr_rd && sfr_addr == 8'h00_c8 |=> !sfr_rdata[5])
        else $error("reserved bit read as one");
    rd_map_a: assert property (sfr_rd && sfr_addr == 8'h00_c8 |=> {sfr_rdata[7:6],
        sfr_rdata[4:3]} == $past({rx_overrun_flag, parity_error_flag, receive_enable,
        transmit_extra_bit}))
        else $error("control read does not match flags");
    idle_read_a: assert property (!sfr_rd |=> sfr_rdata == 8'h00_00)
        else $error("read data not idle");
    rx_off_a: assert property ((!receive_enable)[*3] ##0 !receive_pending_flag
        |=> !receive_pending_flag)
        else $error("byte stored while receiver off");
    pend_set_a: assert property (receive_enable && rx_char.valid && !multiproc_enable
        ##0 (!sfr_rd)[*3] |-> receive_pending_flag)
        else $error("pending flag missing after a stored byte");
    pend_fall_a: assert property ($fell(receive_pending_flag) |-> $past(sfr_rd, 2))
        else $error("pending flag fell without a read");
    // main scenarios reached
    cover property ($rose(rx_overrun_flag));
    cover property ($rose(parity_error_flag));
    cover property ($rose(receive_pending_flag));
endmodule : uart_serial_control_asserts
bind uart_serial_control uart_serial_control_asserts u_uart_serial_control_asserts (
    .ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_bit_wr, .sfr_rd, .sfr_wdata, .sfr_bit_val,
    .rx_char, .multiproc_enable, .sfr_rdata, .rx_overrun_flag, .parity_error_flag,
    .receive_enable, .transmit_extra_bit, .receive_pending_flag);

/* bench/rx_char_sender.sv */
// remote transmitter model handing characters to the receive path
`timescale 1ns/10ps
module rx_char_sender (
    input wire logic ref_clk,
    output uart_ctrl_pkg::rx_char_type rx_char,
    output logic rx_parity_bit
);
    // idle line carries no character
    initial begin
        rx_char = '0;
        rx_parity_bit = 1'b0;
    end
    // one character, valid for a single cycle, parity per type unless spoilt
    task automatic send(input logic [7:0] d, input logic x, input logic s,
                        input logic [1:0] t, input logic bad);
        logic p;
        p = (t == 2'h0) ? ~^d : (t == 2'h1) ? ^d : (t == 2'h2);
        @(posedge ref_clk);
        rx_char <= '{1'b1, d, x, s};
        rx_parity_bit <= p ^ bad;
        @(posedge ref_clk);
        // released fields flip so no stale value passes for the last one
        rx_char <= '{1'b0, ~d, ~x, ~s};
        rx_parity_bit <= ~(p ^ bad);
    endtask : send
endmodule : rx_char_sender

/* bench/uart_serial_control_tb_top.sv */
// self-checking bench for the serial control register
`timescale 1ns/10ps
module uart_serial_control_tb_top;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] sfr_addr = 8'h00_00;
    logic sfr_wr = 1'b0;
    logic sfr_bit_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00_00;
    logic tx_done = 1'b0;
    logic parity_enable = 1'b0;
    logic [1:0] parity_type = 2'h0;
    logic extra_bit_mode_enable = 1'b0;
    logic multiproc_enable = 1'b0;
    uart_ctrl_pkg::rx_char_type rx_char;
    logic rx_parity_bit;
    logic [7:0] sfr_rdata;
    logic [7:0] rv;
    logic rx_overrun_flag;
    logic parity_error_flag;
    logic receive_enable;
    logic transmit_extra_bit;
    logic extra_receive_bit;
    logic transmit_done_flag;
    logic receive_pending_flag;
    logic [7:0] out_vec;
    // flag outputs laid out in register bit order for direct comparison
    assign out_vec = {rx_overrun_flag, parity_error_flag, 1'b0, receive_enable,
                      transmit_extra_bit, extra_receive_bit, transmit_done_flag,
                      receive_pending_flag};
    logic [9:0] q[$];
    int n_fail = 0;
    int n_compared = 0;
    always #50 ref_clk = ~ref_clk;
    uart_serial_control u_uart_serial_control (
        .ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_bit_wr, .sfr_rd, .sfr_wdata,
        .sfr_bit_val(sfr_wdata[0]), .rx_char, .rx_parity_bit, .tx_done, .parity_enable,
        .parity_type, .extra_bit_mode_enable, .multiproc_enable, .sfr_rdata,
        .rx_overrun_flag, .parity_error_flag, .receive_enable, .transmit_extra_bit,
        .extra_receive_bit, .transmit_done_flag, .receive_pending_flag);
    rx_char_sender u_rx_char_sender (.ref_clk, .rx_char, .rx_parity_bit);
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    // byte write, or bit write of data bit 0 when bit_op is set
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bit_op);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wdata <= d;
        sfr_wr <= !bit_op;
        sfr_bit_wr <= bit_op;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
        sfr_bit_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_rd <= 1'b1;
        @(posedge ref_clk);
        sfr_rd <= 1'b0;
        #1 rv = sfr_rdata;
    endtask : rd
    task automatic report_and_stop();
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_fail++;
        report_and_stop();
    end
    // main sequence
    initial begin
        logic [7:0] d;
        logic x;
        logic s;
        d = 8'($urandom(69));
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        rd(8'h00_c8);
        chk(rv, 8'h00_00);
        wr(8'h00_c8, 8'h00_ff, 1'b0);
        rd(8'h00_c8);
        chk(rv, 8'h00_da);
        // start the single bit walk from an all clear register
        wr(8'h00_c8, 8'h00_00, 1'b0);
        for (int b = 0; b < 8; b++) begin
            wr(8'h00_c0 | 8'(b + 8), 8'h00_01, 1'b0 | 1'b1);
            rd(8'h00_c8);
            chk(rv, 8'h00_da & (8'h00_01 << b));
            wr(8'h00_c0 | 8'(b + 8), 8'h00_00, 1'b1);
        end
        @(posedge ref_clk);
        tx_done <= 1'b1;
        @(posedge ref_clk);
        tx_done <= 1'b0;
        rd(8'h00_c8);
        chk(rv, 8'h00_02);
        chk(out_vec, 8'h00_02);
        rd(8'h00_55);
        chk(rv, 8'h00_00);
        wr(8'h00_c8, 8'h00_10, 1'b0);
        // random bursts read back in order with pending and extra bits
        for (int i = 0; i < 24; i++) begin
            @(posedge ref_clk);
            extra_bit_mode_enable <= 1'($urandom);
            repeat (1 + $urandom % 2) begin
                d = 8'($urandom);
                x = 1'($urandom);
                s = 1'($urandom);
                q.push_back({d, x, s});
                u_rx_char_sender.send(d, x, s, 2'h0, 1'b0);
            end
            repeat (3) @(posedge ref_clk);
            while (q.size() > 0) begin
                rd(8'h00_c8);
                chk(rv & 8'h00_05, {5'h00, extra_bit_mode_enable ? q[0][1] : q[0][0], 2'h1});
                chk(out_vec & 8'h00_05, {5'h00, extra_bit_mode_enable ? q[0][1] : q[0][0],
                    2'h1});
                rd(8'h00_99);
                chk(rv, q.pop_front() >> 2);
            end
            rd(8'h00_c8);
            chk(rv & 8'h00_81, 8'h00_00);
        end
        // third byte into a full fifo is dropped and flagged
        u_rx_char_sender.send(8'h00_a5, 1'b0, 1'b1, 2'h0, 1'b0);
        u_rx_char_sender.send(8'h00_5a, 1'b0, 1'b1, 2'h0, 1'b0);
        u_rx_char_sender.send(8'h00_c3, 1'b0, 1'b1, 2'h0, 1'b0);
        repeat (4) @(posedge ref_clk);
        rd(8'h00_99);
        chk(rv, 8'h00_a5);
        rd(8'h00_99);
        chk(rv, 8'h00_5a);
        rd(8'h00_c8);
        chk(rv & 8'h00_81, 8'h00_80);
        chk(out_vec & 8'h00_81, 8'h00_80);
        wr(8'h00_cf, 8'h00_00, 1'b1);
        rd(8'h00_c8);
        chk(rv & 8'h00_80, 8'h00_00);
        // good head keeps the parity flag clear, bad head sets it and it stays set after the read until cleared
        for (int t = 0; t < 4; t++) begin
            @(posedge ref_clk);
            parity_type <= 2'(t);
            parity_enable <= 1'b1;
            u_rx_char_sender.send(8'($urandom), 1'b0, 1'b1, 2'(t), 1'b0);
            u_rx_char_sender.send(8'h00_3c, 1'b0, 1'b1, 2'(t), 1'b1);
            repeat (3) @(posedge ref_clk);
            rd(8'h00_c8);
            chk(rv & 8'h00_40, 8'h00_00);
            rd(8'h00_99);
            wr(8'h00_ce, 8'h00_00, 1'b1);
            rd(8'h00_c8);
            chk(rv & 8'h00_40, 8'h00_40);
            rd(8'h00_99);
            rd(8'h00_c8);
            chk(rv & 8'h00_40, 8'h00_40);
            chk(out_vec & 8'h00_40, 8'h00_40);
            wr(8'h00_ce, 8'h00_00, 1'b1);
            rd(8'h00_c8);
            chk(rv & 8'h00_40, 8'h00_00);
        end
        // receiver off: stored byte still readable, new byte ignored
        u_rx_char_sender.send(8'h00_66, 1'b0, 1'b1, 2'h0, 1'b0);
        wr(8'h00_c8, 8'h00_00, 1'b0);
        u_rx_char_sender.send(8'h00_77, 1'b0, 1'b1, 2'h0, 1'b0);
        rd(8'h00_99);
        chk(rv, 8'h00_66);
        repeat (3) @(posedge ref_clk);
        rd(8'h00_c8);
        chk(rv & 8'h00_81, 8'h00_00);
        report_and_stop();
    end
endmodule : uart_serial_control_tb_top
